//--- verilog/hbp_pkg.sv
// Constants and types shared by the host bus port files
package hbp_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W  = 18;
    localparam int DATA_W  = 16;
    localparam int PANEL_W = 18;
    localparam int STRAP_W = 3;

    // ----------------------------------------------------------------
    // Bus personality strap layout
    // ----------------------------------------------------------------
    localparam int STRAP_INDIRECT_BIT = 2;
    localparam logic [1:0] STYLE_68  = 2'h0;
    localparam logic [1:0] STYLE_80A = 2'h1;
    localparam logic [1:0] STYLE_80B = 2'h2;
    localparam logic [1:0] STYLE_80C = 2'h3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [STRAP_W-1:0] STRAP_RST      = 3'h0;
    localparam logic [1:0]         STRAP_LOAD_CNT = 2'h3;
    localparam logic [ADDR_W-1:0]  ADDR_ZERO      = 18'h00000;
    localparam logic [DATA_W-1:0]  DATA_ZERO      = 16'h0000;
    localparam logic [PANEL_W-DATA_W-1:0] PANEL_PAD = 2'h0;
    localparam logic [PANEL_W-1:0] PANEL_ZERO     = 18'h00000;
    localparam logic [1:0]         LANES_NONE     = 2'h0;
    localparam logic [1:0]         LANES_BOTH     = 2'h3;

    // ----------------------------------------------------------------
    // Host cycle states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HBP_IDLE = 2'b00,
        HBP_WAIT = 2'b01,
        HBP_DONE = 2'b10,
        HBP_END  = 2'b11
    } hbp_state_t;

endpackage

//--- verilog/hbp_sync.sv
// Two-flop synchroniser for a group of pin inputs
module hbp_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= RST;
            dout   <= RST;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

//--- verilog/hbp_host_bus_port.sv
// Asynchronous 16-bit host CPU port with strap-selected personality
// What this block does
// - Single select: high space select picks display buffer, low picks registers.
// - Dual select: chip select pin becomes the memory-space select.
// - Dual select: space select pin becomes the register-space chip select.
// - Read pin: read strobe in types 1/2, low-byte read in type 3.
// - Write pin: read/write in 68, write in type 1, low write in type 3.
// - Upper lane pin: upper strobe, enable, write or read per personality.
// - Lower lane pin: lower strobe, enable, write, or upper write in type 3.
// - Stall held low during transfer, driven high at completion, then released.
// - Stall mask strap keeps the stall output from asserting.
// - Interrupt output high while pending, low after host clears it.
// - Reset pin low loads defaults and forces signals inactive.
// - Bus personality sampled from strap pins at power-on or reset.
// - Serial bypass: bypass chip select is host serial chip select.
// - Serial bypass: clock, command select and data take serial roles.
// - Parallel bypass: clock pin is write command, select is command/data.
// - Parallel bypass: chip select is panel two, data pin is panel one.
// - Power save or serial bypass passes serial pins to panel outputs.
// - Parallel bypass presents host data word on panel data bus.
module hbp_host_bus_port
    import hbp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Host pins
    input  wire logic               resetPinN,
    input  wire logic [STRAP_W-1:0] hostBusTypeStrap,
    input  wire logic               stallMaskStrap,
    input  wire logic               dualChipSelStrap,
    input  wire logic               hostChipSelN,
    input  wire logic               memOrRegSel,
    input  wire logic               readStrbN,
    input  wire logic               writeStrbN,
    input  wire logic               upperLaneSelN,
    input  wire logic               lowLaneSelN,
    input  wire logic [ADDR_W-1:0]  hostAddrBus,
    input  wire logic [DATA_W-1:0]  hostDataIn,
    output logic      [DATA_W-1:0]  hostDataOut,
    output logic                    hostDataOeN,
    output logic                    hostStallN,
    output logic                    hostStallOeN,
    output logic                    irqOut,
    // Bypass pins
    input  wire logic               bypassChipSelN,
    input  wire logic               bypassSerialClk,
    input  wire logic               bypassCmdDataSel,
    input  wire logic               bypassSerialDin,
    // Mode controls from internal logic
    input  wire logic               serialBypassEn,
    input  wire logic               parallelBypassEn,
    input  wire logic               powerSaveEn,
    input  wire logic               irqEvent,
    input  wire logic               irqClear,
    // Panel outputs
    output logic                    panel2ChipSelN,
    output logic                    panel1ChipSelN,
    output logic                    panelSerialClk,
    output logic                    panelCmdDataSel,
    output logic                    panelSerialDout,
    output logic                    panelWriteCmd,
    output logic      [PANEL_W-1:0] panelDataBus,
    // Internal access side
    output logic                    accReq,
    output logic                    accIsMem,
    output logic                    accIsWrite,
    output logic                    accIndirect,
    output logic      [1:0]         accLanes,
    output logic      [ADDR_W-1:0]  accAddr,
    output logic      [DATA_W-1:0]  accWdata,
    input  wire logic               accDone,
    input  wire logic [DATA_W-1:0]  accRdata,
    output logic      [STRAP_W-1:0] busType,
    output logic                    stallMasked
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam int CTRL_W = 12;

    logic [CTRL_W-1:0]  ctrlSync;
    logic [ADDR_W-1:0]  addrSync;
    logic [DATA_W-1:0]  dataSync;
    logic [STRAP_W-1:0] strapSync;
    logic               rstPinSync;
    logic               csN;
    logic               spaceSel;
    logic               rdN;
    logic               weN;
    logic               upN;
    logic               loN;
    logic               byCsN;
    logic               bySclk;
    logic               byA0;
    logic               bySi;
    logic               maskSync;
    logic               dualSync;

    hbp_sync #(.W(CTRL_W), .RST(12'hFFF)) u_ctrl_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     ({hostChipSelN, memOrRegSel, readStrbN, writeStrbN,
                   upperLaneSelN, lowLaneSelN, bypassChipSelN, bypassSerialClk,
                   bypassCmdDataSel, bypassSerialDin, stallMaskStrap,
                   dualChipSelStrap}),
        .dout    (ctrlSync)
    );

    hbp_sync #(.W(ADDR_W), .RST(ADDR_ZERO)) u_addr_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (hostAddrBus),
        .dout    (addrSync)
    );

    hbp_sync #(.W(DATA_W), .RST(DATA_ZERO)) u_data_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (hostDataIn),
        .dout    (dataSync)
    );

    hbp_sync #(.W(STRAP_W + 1), .RST(4'h0)) u_strap_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     ({hostBusTypeStrap, resetPinN}),
        .dout    ({strapSync, rstPinSync})
    );

    assign csN      = ctrlSync[11];
    assign spaceSel = ctrlSync[10];
    assign rdN      = ctrlSync[9];
    assign weN      = ctrlSync[8];
    assign upN      = ctrlSync[7];
    assign loN      = ctrlSync[6];
    assign byCsN    = ctrlSync[5];
    assign bySclk   = ctrlSync[4];
    assign byA0     = ctrlSync[3];
    assign bySi     = ctrlSync[2];
    assign maskSync = ctrlSync[1];
    assign dualSync = ctrlSync[0];

    logic pinRst;
    assign pinRst = ~rstPinSync;

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Sampled while the reset pin is held and a few cycles after power-on,
    // long enough for the strap synchronisers to settle.
    logic [1:0] strapCnt_r;
    logic       dualCs_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapCnt_r <= STRAP_LOAD_CNT;
        end else if (pinRst) begin
            strapCnt_r <= STRAP_LOAD_CNT;
        end else if (strapCnt_r != 2'h0) begin
            strapCnt_r <= strapCnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busType     <= STRAP_RST;
            stallMasked <= 1'b0;
            dualCs_r    <= 1'b0;
        end else if (strapCnt_r != 2'h0) begin
            busType     <= strapSync;
            stallMasked <= maskSync;
            dualCs_r    <= dualSync;
        end
    end

    logic [1:0] style;
    logic       indirect;
    assign style    = busType[1:0];
    assign indirect = busType[STRAP_INDIRECT_BIT];

    // ----------------------------------------------------------------
    // Pin role decode
    // ----------------------------------------------------------------
    logic sel;
    logic isMem;
    logic rdLo;
    logic rdHi;
    logic wrLo;
    logic wrHi;

    always_comb begin
        if (dualCs_r) begin
            sel   = ~csN | ~spaceSel;
            isMem = ~csN;
        end else begin
            sel   = ~csN;
            isMem = spaceSel;
        end
        rdLo = 1'b0;
        rdHi = 1'b0;
        wrLo = 1'b0;
        wrHi = 1'b0;
        unique case (style)
            STYLE_68: begin
                rdHi = weN & ~upN;
                rdLo = weN & ~loN;
                wrHi = ~weN & ~upN;
                wrLo = ~weN & ~loN;
            end
            STYLE_80A: begin
                rdHi = ~rdN & ~upN;
                rdLo = ~rdN & ~loN;
                wrHi = ~weN & ~upN;
                wrLo = ~weN & ~loN;
            end
            STYLE_80B: begin
                rdHi = ~rdN;
                rdLo = ~rdN;
                wrHi = ~upN;
                wrLo = ~loN;
            end
            STYLE_80C: begin
                rdLo = ~rdN;
                rdHi = ~upN;
                wrLo = ~weN;
                wrHi = ~loN;
            end
        endcase
    end

    logic anyRd;
    logic anyWr;
    logic cycleOn;
    assign anyRd   = rdLo | rdHi;
    assign anyWr   = wrLo | wrHi;
    assign cycleOn = sel & (anyRd | anyWr);

    // ----------------------------------------------------------------
    // Host cycle sequencer
    // ----------------------------------------------------------------
    hbp_state_t state_r;
    hbp_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            HBP_IDLE: if (cycleOn) state_nxt = HBP_WAIT;
            HBP_WAIT: if (accDone) state_nxt = HBP_DONE;
            HBP_DONE: state_nxt = HBP_END;
            HBP_END:  if (!cycleOn) state_nxt = HBP_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= HBP_IDLE;
        end else if (pinRst) begin
            state_r <= HBP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request toward the internal spaces
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            accReq      <= 1'b0;
            accIsMem    <= 1'b0;
            accIsWrite  <= 1'b0;
            accIndirect <= 1'b0;
            accLanes    <= LANES_NONE;
            accAddr     <= ADDR_ZERO;
            accWdata    <= DATA_ZERO;
        end else if (pinRst) begin
            accReq      <= 1'b0;
            accIsMem    <= 1'b0;
            accIsWrite  <= 1'b0;
            accIndirect <= 1'b0;
            accLanes    <= LANES_NONE;
            accAddr     <= ADDR_ZERO;
            accWdata    <= DATA_ZERO;
        end else begin
            accReq <= (state_r == HBP_IDLE) && cycleOn;
            if ((state_r == HBP_IDLE) && cycleOn) begin
                accIsMem    <= isMem;
                accIsWrite  <= anyWr;
                accIndirect <= indirect;
                accLanes    <= anyWr ? {wrHi, wrLo} : {rdHi, rdLo};
                accWdata    <= dataSync;
                accAddr     <= indirect ? ADDR_ZERO : addrSync;
            end
        end
    end

    // Stall line: low while waiting, high at completion, then released
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hostStallN   <= 1'b1;
            hostStallOeN <= 1'b1;
        end else if (pinRst) begin
            hostStallN   <= 1'b1;
            hostStallOeN <= 1'b1;
        end else begin
            hostStallN   <= ~(state_nxt == HBP_WAIT);
            hostStallOeN <= stallMasked |
                            ~((state_nxt == HBP_WAIT) || (state_nxt == HBP_DONE));
        end
    end

    // Read data held on the bus until the host drops its strobes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hostDataOut <= DATA_ZERO;
            hostDataOeN <= 1'b1;
        end else if (pinRst) begin
            hostDataOut <= DATA_ZERO;
            hostDataOeN <= 1'b1;
        end else begin
            if ((state_r == HBP_WAIT) && accDone && !accIsWrite) begin
                hostDataOut <= accRdata;
                hostDataOeN <= 1'b0;
            end else if (state_nxt == HBP_IDLE) begin
                hostDataOeN <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    // Set wins over clear so an event in the clearing cycle survives
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqOut <= 1'b0;
        end else if (pinRst) begin
            irqOut <= 1'b0;
        end else begin
            if (irqEvent) begin
                irqOut <= 1'b1;
            end else if (irqClear) begin
                irqOut <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Panel bypass paths
    // ----------------------------------------------------------------
    // Three flops of latency on every bypassed pin; slow serial and
    // parallel panel timing easily absorbs 15 ns.
    logic serialPass;
    assign serialPass = serialBypassEn | powerSaveEn;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            panel2ChipSelN  <= 1'b1;
            panel1ChipSelN  <= 1'b1;
            panelSerialClk  <= 1'b0;
            panelCmdDataSel <= 1'b0;
            panelSerialDout <= 1'b0;
            panelWriteCmd   <= 1'b0;
            panelDataBus    <= PANEL_ZERO;
        end else if (pinRst) begin
            panel2ChipSelN  <= 1'b1;
            panel1ChipSelN  <= 1'b1;
            panelSerialClk  <= 1'b0;
            panelCmdDataSel <= 1'b0;
            panelSerialDout <= 1'b0;
            panelWriteCmd   <= 1'b0;
            panelDataBus    <= PANEL_ZERO;
        end else if (serialPass) begin
            panel2ChipSelN  <= byCsN;
            panel1ChipSelN  <= 1'b1;
            panelSerialClk  <= bySclk;
            panelCmdDataSel <= byA0;
            panelSerialDout <= bySi;
            panelWriteCmd   <= 1'b0;
            panelDataBus    <= PANEL_ZERO;
        end else if (parallelBypassEn) begin
            panel2ChipSelN  <= byCsN;
            panel1ChipSelN  <= bySi;
            panelWriteCmd   <= bySclk;
            panelCmdDataSel <= byA0;
            panelSerialClk  <= 1'b0;
            panelSerialDout <= 1'b0;
            panelDataBus    <= {PANEL_PAD, dataSync};
        end else begin
            panel2ChipSelN  <= 1'b1;
            panel1ChipSelN  <= 1'b1;
            panelSerialClk  <= 1'b0;
            panelCmdDataSel <= 1'b0;
            panelSerialDout <= 1'b0;
            panelWriteCmd   <= 1'b0;
            panelDataBus    <= PANEL_ZERO;
        end
    end

endmodule

//--- tb/hbp_host_bus_port_asserts.sv
// Concurrent checks on the host bus port pins
module hbp_host_bus_port_asserts
    import hbp_pkg::*;
(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               resetPinN,
    input wire logic [DATA_W-1:0]  hostDataIn,
    input wire logic               hostDataOeN,
    input wire logic               hostStallN,
    input wire logic               hostStallOeN,
    input wire logic               irqOut,
    input wire logic               irqEvent,
    input wire logic               irqClear,
    input wire logic               bypassChipSelN,
    input wire logic               bypassSerialClk,
    input wire logic               bypassSerialDin,
    input wire logic               serialBypassEn,
    input wire logic               parallelBypassEn,
    input wire logic               powerSaveEn,
    input wire logic               panel2ChipSelN,
    input wire logic               panel1ChipSelN,
    input wire logic               panelSerialClk,
    input wire logic               panelSerialDout,
    input wire logic               panelWriteCmd,
    input wire logic [PANEL_W-1:0] panelDataBus,
    input wire logic               accReq,
    input wire logic               accDone,
    input wire logic               stallMasked
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_mask_no_stall: assert property (stallMasked |-> hostStallOeN)
        else $error("stall driven while masked");
    a_req_stall_low: assert property (accReq && !stallMasked |-> !hostStallN && !hostStallOeN)
        else $error("stall not low at request");
    a_wait_holds: assert property (!hostStallN && !hostStallOeN && !accDone |=> !hostStallN)
        else $error("stall left early");
    a_done_release: assert property (accDone && !hostStallOeN
        |=> hostStallN && !hostStallOeN ##1 hostStallOeN)
        else $error("stall completion sequence wrong");
    a_irq_set: assert property (irqEvent |=> irqOut)
        else $error("interrupt not raised");
    a_irq_clear: assert property (irqClear && !irqEvent |=> !irqOut)
        else $error("interrupt not cleared");
    a_pin_reset: assert property (!resetPinN [*4] |-> hostStallOeN && hostDataOeN && !irqOut
        && !accReq && panel2ChipSelN)
        else $error("outputs active under reset pin");
    a_serial_pass: assert property ((serialBypassEn || powerSaveEn) [*5]
        |-> panel2ChipSelN == $past(bypassChipSelN, 3)
        && panelSerialClk == $past(bypassSerialClk, 3)
        && panelSerialDout == $past(bypassSerialDin, 3))
        else $error("serial pass-through wrong");
    a_par_pass: assert property ((parallelBypassEn && !serialBypassEn && !powerSaveEn) [*5]
        |-> panelDataBus == {PANEL_PAD, $past(hostDataIn, 3)}
        && panel1ChipSelN == $past(bypassSerialDin, 3)
        && panelWriteCmd == $past(bypassSerialClk, 3))
        else $error("parallel pass-through wrong");
endmodule

bind hbp_host_bus_port hbp_host_bus_port_asserts u_chk (.*);

//--- tb/hbp_acc_model.sv
// Internal access responder standing behind the host port
module hbp_acc_model
    import hbp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              accReq,
    input  wire logic [ADDR_W-1:0] accAddr,
    input  wire logic [3:0]        accDelay,
    output logic                   accDone,
    output logic      [DATA_W-1:0] accRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        accDone = 1'b0;
        accRdata = 16'h0000;
        forever begin
            @(posedge clk);
            if (accReq === 1'b1 && sys_rst === 1'b0) begin
                repeat (accDelay) @(posedge clk);
                accDone <= 1'b1;
                accRdata <= accAddr[DATA_W-1:0] ^ 16'h5AC3;
                @(posedge clk);
                accDone <= 1'b0;
                // Stale data inverted so a late sample cannot match
                accRdata <= ~accRdata;
            end
        end
    end
endmodule

//--- tb/tb.sv
// Self-checking bench for the host bus port
module tb
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk, sys_rst, resetPinN, stallMaskStrap, dualChipSelStrap;
    logic               hostChipSelN, memOrRegSel, readStrbN, writeStrbN, upperLaneSelN;
    logic               lowLaneSelN, bypassChipSelN, bypassSerialClk, bypassCmdDataSel;
    logic               bypassSerialDin, serialBypassEn, parallelBypassEn, powerSaveEn;
    logic               irqEvent, irqClear, hostDataOeN, hostStallN, hostStallOeN, irqOut;
    logic               panel2ChipSelN, panel1ChipSelN, panelSerialClk, panelCmdDataSel;
    logic               panelSerialDout, panelWriteCmd, accReq, accIsMem, accIsWrite;
    logic               accIndirect, accDone, stallMasked;
    logic [3:0]         accDelay;
    logic [1:0]         accLanes;
    logic [STRAP_W-1:0] hostBusTypeStrap, busType;
    logic [ADDR_W-1:0]  hostAddrBus, accAddr;
    logic [DATA_W-1:0]  hostDrv, hostDataOut, accWdata, accRdata;
    logic [PANEL_W-1:0] panelDataBus;
    int                 nErrors = 0;
    int                 nTests = 0;
    // Pull-up on the stall line while the port releases it
    wire logic              stallWire = hostStallOeN ? 1'b1 : hostStallN;
    wire logic [DATA_W-1:0] hostDataIn = hostDataOeN ? hostDrv : hostDataOut;

    hbp_host_bus_port u_dut (.*);
    hbp_acc_model     u_mem (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask

    task automatic endSim;
        $display("Errors %0d, tests %0d", nErrors, nTests);
        if (nErrors == 0 && nTests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic boot(input logic [STRAP_W-1:0] s, input logic m);
        @(posedge clk);
        hostBusTypeStrap <= s;
        stallMaskStrap <= m;
        dualChipSelStrap <= s[0] & !s[STRAP_INDIRECT_BIT];
        resetPinN <= 1'b0;
        repeat (6) @(posedge clk);
        resetPinN <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk(busType, s, "personality strap");
        chk(stallMasked, m, "stall mask strap");
    endtask

    task automatic hcyc(input logic rd, input logic mem, input logic [1:0] ln);
        logic              ind;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        int                k;
        ind = hostBusTypeStrap[STRAP_INDIRECT_BIT];
        a = ind ? ADDR_ZERO : ADDR_W'($urandom);
        d = DATA_W'($urandom);
        mem = mem & !ind;
        if (rd) ln = LANES_BOTH;
        @(posedge clk);
        accDelay <= 4'($urandom_range(0, 5));
        // address and space select grounded when indirect
        hostAddrBus <= a;
        memOrRegSel <= mem;
        hostDrv <= d;
        hostChipSelN <= dualChipSelStrap & !mem;
        // strobe pin roles, unused pins tied high
        case (hostBusTypeStrap[1:0])
            STYLE_68: begin
                readStrbN <= 1'b1;
                writeStrbN <= rd;
                upperLaneSelN <= !ln[1];
                lowLaneSelN <= !ln[0];
            end
            STYLE_80A: begin
                readStrbN <= !rd;
                writeStrbN <= rd;
                upperLaneSelN <= !ln[1];
                lowLaneSelN <= !ln[0];
            end
            STYLE_80B: begin
                readStrbN <= !rd;
                writeStrbN <= 1'b1;
                upperLaneSelN <= !(ln[1] & !rd);
                lowLaneSelN <= !(ln[0] & !rd);
            end
            default: begin
                readStrbN <= !(rd & ln[0]);
                upperLaneSelN <= !(rd & ln[1]);
                writeStrbN <= !(!rd & ln[0]);
                lowLaneSelN <= !(!rd & ln[1]);
            end
        endcase
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (accReq !== 1'b1 && k < 20);
        chk(accIsMem, mem, "space select");
        chk(accIsWrite, !rd, "direction");
        chk(accLanes, ln, "byte lanes");
        chk({accIndirect, accAddr}, {ind, a}, "address");
        if (!rd) chk(accWdata, d, "write data");
        // host extends its cycle until completion shows
        k = 0;
        while ((rd ? hostDataOeN !== 1'b0 : accDone !== 1'b1) && k < 30) begin
            @(posedge clk);
            #1 k++;
        end
        chk(k < 30, 1, "access never completed");
        if (rd) chk(hostDataOut, a[DATA_W-1:0] ^ 16'h5AC3, "read data");
        repeat (3) @(posedge clk);
        #1 chk({stallWire, hostStallOeN}, 2'h3, "stall not released");
        @(posedge clk);
        {hostChipSelN, readStrbN, writeStrbN, upperLaneSelN, lowLaneSelN} <= 5'h1F;
        repeat (4) @(posedge clk);
        #1 chk(hostDataOeN, 1, "data bus kept");
    endtask

    task automatic byp(input int mode);
        logic [3:0]        p;
        logic [DATA_W-1:0] d;
        @(posedge clk);
        serialBypassEn <= (mode == 0 || mode == 3);
        parallelBypassEn <= (mode == 1 || mode == 3);
        powerSaveEn <= (mode == 2);
        repeat (6) begin
            @(posedge clk);
            p = 4'($urandom);
            d = DATA_W'($urandom);
            {bypassChipSelN, bypassSerialClk, bypassCmdDataSel, bypassSerialDin} <= p;
            hostDrv <= d;
            repeat (4) @(posedge clk);
            #1;
            if (mode == 1) begin
                chk(panelDataBus, {PANEL_PAD, d}, "panel data");
                chk({panel2ChipSelN, panel1ChipSelN}, {p[3], p[0]}, "panel selects");
                chk({panelWriteCmd, panelCmdDataSel}, p[2:1], "write and select");
            end else begin
                chk(panel2ChipSelN, p[3], "serial select");
                chk({panelSerialClk, panelCmdDataSel, panelSerialDout}, p[2:0], "serial");
            end
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h7256));
        {resetPinN, hostChipSelN, readStrbN, writeStrbN, upperLaneSelN, lowLaneSelN} = 6'h3F;
        {stallMaskStrap, dualChipSelStrap, memOrRegSel, serialBypassEn} = 4'h0;
        {parallelBypassEn, powerSaveEn, irqEvent, irqClear} = 4'h0;
        {bypassChipSelN, bypassSerialClk, bypassCmdDataSel, bypassSerialDin} = 4'h8;
        {hostBusTypeStrap, accDelay, hostAddrBus, hostDrv} = '0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk({hostStallOeN, hostDataOeN, irqOut, panel2ChipSelN}, 4'hD, "reset state");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            irqEvent <= (i != 1);
            irqClear <= (i != 0);
            @(posedge clk);
            {irqEvent, irqClear} <= 2'h0;
            #1 chk(irqOut, i != 1, "interrupt level");
        end
        @(posedge clk);
        irqClear <= 1'b1;
        @(posedge clk);
        irqClear <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            boot(STRAP_W'(s), s == 3 || s == 6);
            for (int j = 0; j < 4; j++) hcyc(j[0], j[1], 2'($urandom_range(1, 3)));
        end
        for (int m = 0; m < 4; m++) byp(m);
        endSim;
    end

    initial begin
        #100000;
        nErrors++;
        $display("Error %0t: watchdog expired", $time);
        endSim;
    end
endmodule
